//--- hdl/light_curtain_monitor.sv
// two-channel light curtain monitor with restart modes and skew check
`timescale 1ns/10ps
module light_curtain_monitor #(
    parameter int TICK_CYCLES = light_curtain_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic curtainChannelOne,
    input wire logic curtainChannelTwo,
    input wire logic restartRequestInput,
    input wire logic runMode,
    input wire logic [1:0] restartMode,
    input wire logic startupCheck,
    input wire logic [2:0] channelSkewLimit,
    output logic safeEnableOutput,
    output logic faultOutput,
    output logic [light_curtain_pkg::COUNT_W-1:0] skewCount
);

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        light_curtain_pkg::monitor_state_e state;
        logic safe;
        logic fault;
        logic [light_curtain_pkg::COUNT_W-1:0] count;
        logic [light_curtain_pkg::DIV_W-1:0] div;
        logic runPrev;
        logic startDropped;
        logic startRstSeen;
    } monitor_s;

    monitor_s cur_ff;
    monitor_s nxt_cur;

    logic [2:0] pinsSync;
    logic chOne;
    logic chTwo;
    logic rstReq;
    logic bothOn;
    logic bothOff;
    logic msTick;
    logic [light_curtain_pkg::COUNT_W-1:0] limitMs;
    logic skewExpired;
    light_curtain_pkg::restart_mode_e mode;

    // limit in ms; zero setting disables skew monitoring
    function automatic logic [light_curtain_pkg::COUNT_W-1:0] skewLimitMs(input logic [2:0] sel);
        skewLimitMs = light_curtain_pkg::COUNT_W'(sel * light_curtain_pkg::SKEW_STEP_MS);
    endfunction

    // pins come from the field and are asynchronous
    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .clock(clock),
        .rst_n(rst_n),
        .pinIn({restartRequestInput, curtainChannelTwo, curtainChannelOne}),
        .pinSync(pinsSync)
    );

    assign chOne = pinsSync[0];
    assign chTwo = pinsSync[1];
    assign rstReq = pinsSync[2];
    assign bothOn = chOne & chTwo;
    assign bothOff = !chOne & !chTwo;
    assign mode = light_curtain_pkg::restart_mode_e'(restartMode);
    assign limitMs = skewLimitMs(channelSkewLimit);
    assign msTick = (cur_ff.div == light_curtain_pkg::DIV_W'(TICK_CYCLES - 1));
    assign skewExpired = (limitMs != light_curtain_pkg::COUNT_RESET) && (cur_ff.count >= limitMs);

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.runPrev = runMode;
        nxt_cur.div = msTick ? light_curtain_pkg::DIV_RESET : cur_ff.div + 1'b1;
        unique case (cur_ff.state)
            light_curtain_pkg::ST_STARTUP: begin
                // operator must interrupt, then press and release reset
                if (bothOff) begin
                    nxt_cur.startDropped = 1'b1;
                end
                if (cur_ff.startDropped && rstReq) begin
                    nxt_cur.startRstSeen = 1'b1;
                end
                if (cur_ff.startRstSeen && !rstReq) begin
                    nxt_cur.state = light_curtain_pkg::ST_WAIT_FIRST;
                end
            end
            light_curtain_pkg::ST_WAIT_FIRST: begin
                if (bothOn) begin
                    nxt_cur.fault = 1'b0;
                    nxt_cur.state = light_curtain_pkg::ST_CLEARED;
                end else if (chOne || chTwo) begin
                    nxt_cur.count = light_curtain_pkg::COUNT_RESET;
                    nxt_cur.state = light_curtain_pkg::ST_WAIT_SECOND;
                end
            end
            light_curtain_pkg::ST_WAIT_SECOND: begin
                if (msTick) begin
                    nxt_cur.count = cur_ff.count + 1'b1;
                end
                if (bothOn) begin
                    nxt_cur.fault = 1'b0;
                    nxt_cur.state = light_curtain_pkg::ST_CLEARED;
                end else if (skewExpired) begin
                    nxt_cur.fault = 1'b1;
                    nxt_cur.state = light_curtain_pkg::ST_FAULT;
                end else if (bothOff) begin
                    nxt_cur.state = light_curtain_pkg::ST_WAIT_FIRST;
                end
            end
            light_curtain_pkg::ST_FAULT: begin
                // acknowledge starts from a full dropout or from a run/stop change
                if (bothOff) begin
                    nxt_cur.state = light_curtain_pkg::ST_WAIT_FIRST;
                end
            end
            light_curtain_pkg::ST_CLEARED: begin
                if (!bothOn) begin
                    nxt_cur.state = light_curtain_pkg::ST_WAIT_FIRST;
                end else if (mode == light_curtain_pkg::AUTO_RESTART_MODE) begin
                    nxt_cur.state = light_curtain_pkg::ST_ENABLED;
                end else begin
                    nxt_cur.state = light_curtain_pkg::ST_WAIT_RST_HI;
                end
            end
            light_curtain_pkg::ST_WAIT_RST_HI: begin
                if (!bothOn) begin
                    nxt_cur.state = light_curtain_pkg::ST_WAIT_FIRST;
                end else if (rstReq) begin
                    // manual acts on press, controlled waits for release
                    nxt_cur.state = (mode == light_curtain_pkg::CONTROLLED_RESTART_MODE) ?
                        light_curtain_pkg::ST_WAIT_RST_LO : light_curtain_pkg::ST_ENABLED;
                end
            end
            light_curtain_pkg::ST_WAIT_RST_LO: begin
                if (!bothOn) begin
                    nxt_cur.state = light_curtain_pkg::ST_WAIT_FIRST;
                end else if (!rstReq) begin
                    nxt_cur.state = light_curtain_pkg::ST_ENABLED;
                end
            end
            light_curtain_pkg::ST_ENABLED: begin
                if (!bothOn) begin
                    nxt_cur.state = light_curtain_pkg::ST_WAIT_FIRST;
                end
            end
        endcase
        // run/stop edge restarts the block, startup check on a stop-to-run edge if configured
        if (runMode != cur_ff.runPrev) begin
            nxt_cur.startDropped = 1'b0;
            nxt_cur.startRstSeen = 1'b0;
            nxt_cur.state = startupCheck ? light_curtain_pkg::ST_STARTUP : light_curtain_pkg::ST_WAIT_FIRST;
        end
        if (!runMode) begin
            nxt_cur.state = light_curtain_pkg::ST_WAIT_FIRST;
        end
        // enable follows the next state so a dropout opens it at once
        nxt_cur.safe = runMode && (nxt_cur.state == light_curtain_pkg::ST_ENABLED) && !nxt_cur.fault;
    end

    // single register for all block state apart from the pin synchroniser stages
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '{state: light_curtain_pkg::ST_WAIT_FIRST, safe: 1'b0, fault: 1'b0,
                        count: light_curtain_pkg::COUNT_RESET, div: light_curtain_pkg::DIV_RESET,
                        runPrev: 1'b0, startDropped: 1'b0, startRstSeen: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign safeEnableOutput = cur_ff.safe;
    assign faultOutput = cur_ff.fault;
    assign skewCount = cur_ff.count;

    // ************************************************
    // checks
    // ************************************************
    a_drop_opens_enable: assert property (@(posedge clock) disable iff (!rst_n)
        (cur_ff.state == light_curtain_pkg::ST_ENABLED && !bothOn) |=> !safeEnableOutput)
        else $error("enable stayed on after beam interruption");

    a_fault_blocks_enable: assert property (@(posedge clock) disable iff (!rst_n)
        faultOutput |-> !safeEnableOutput)
        else $error("enable on while fault present");

    a_skew_timeout_fault: assert property (@(posedge clock) disable iff (!rst_n)
        (cur_ff.state == light_curtain_pkg::ST_WAIT_SECOND && skewExpired && !bothOn && runMode
         && runMode == cur_ff.runPrev) |=> faultOutput)
        else $error("skew timeout did not raise fault");

    a_fault_clear_path: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(faultOutput) |-> ($past(bothOn) && $past(cur_ff.state) != light_curtain_pkg::ST_FAULT))
        else $error("fault cleared without dropout and reclose");

    a_auto_reenable: assert property (@(posedge clock) disable iff (!rst_n)
        (cur_ff.state == light_curtain_pkg::ST_CLEARED && bothOn && runMode && runMode == cur_ff.runPrev
         && mode == light_curtain_pkg::AUTO_RESTART_MODE) |=> safeEnableOutput)
        else $error("auto mode did not re-enable");

    a_startup_holds: assert property (@(posedge clock) disable iff (!rst_n)
        (startupCheck && runMode && !cur_ff.runPrev) |=> (!safeEnableOutput && cur_ff.state == light_curtain_pkg::ST_STARTUP)[*2])
        else $error("startup check not held after run change");

    a_controlled_release: assert property (@(posedge clock) disable iff (!rst_n)
        ($rose(safeEnableOutput) && mode == light_curtain_pkg::CONTROLLED_RESTART_MODE)
        |-> ($past(cur_ff.state) == light_curtain_pkg::ST_WAIT_RST_LO && !$past(rstReq)))
        else $error("controlled enable without reset release");

    a_count_restart: assert property (@(posedge clock) disable iff (!rst_n)
        (cur_ff.state == light_curtain_pkg::ST_WAIT_SECOND && $past(cur_ff.state) != light_curtain_pkg::ST_WAIT_SECOND)
        |-> skewCount == light_curtain_pkg::COUNT_RESET)
        else $error("skew counter not restarted at first channel");

endmodule

//--- hdl/light_curtain_pkg.sv
// shared constants and types for the light curtain monitor
package light_curtain_pkg;

    // ************************************************
    // timing
    // ************************************************
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_NS = 1000000;  // one millisecond time base
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam int SKEW_STEP_MS = 500;        // skew limit granularity
    localparam int COUNT_W = 12;
    localparam int DIV_W = 18;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 12'h000;
    localparam logic [DIV_W-1:0] DIV_RESET = 18'h00000;

    // ************************************************
    // modes and states
    // ************************************************
    typedef enum logic [1:0] {
        AUTO_RESTART_MODE = 2'h0,
        MANUAL_RESTART_MODE = 2'h1,
        CONTROLLED_RESTART_MODE = 2'h2
    } restart_mode_e;

    // gray codes along the auto and controlled clear -> enable paths; manual ST_WAIT_RST_HI -> ST_ENABLED changes two bits
    typedef enum logic [2:0] {
        ST_WAIT_FIRST = 3'h0,
        ST_WAIT_SECOND = 3'h1,
        ST_CLEARED = 3'h3,
        ST_WAIT_RST_HI = 3'h2,
        ST_WAIT_RST_LO = 3'h6,
        ST_ENABLED = 3'h7,
        ST_FAULT = 3'h5,
        ST_STARTUP = 3'h4
    } monitor_state_e;

endpackage

//--- hdl/pin_sync.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinSync
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= pinIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign pinSync = stage2_ff;

endmodule

//--- bench/curtain_model.sv
// behavioural light curtain with two outputs and a reset pushbutton
`timescale 1ns/10ps
// ************************************************
// curtain model
// ************************************************
module curtain_model (
    input wire logic clock,
    input wire logic beamClear,
    input wire logic [15:0] skewCycles,
    input wire logic pressBtn,
    output logic chOne,
    output logic chTwo,
    output logic button
);
    logic [15:0] cnt;
    initial begin
        chOne = 1'b0;
        chTwo = 1'b0;
        button = 1'b0;
        cnt = 16'h0000;
    end
    // channel two lags channel one by a set skew; both drop at once
    always @(posedge clock) begin
        chOne <= beamClear;
        button <= pressBtn;
        if (!beamClear) begin
            chTwo <= 1'b0;
            cnt <= 16'h0000;
        end else if (cnt >= skewCycles) begin
            chTwo <= 1'b1;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
endmodule

//--- bench/light_curtain_monitor_tb.sv
// self-checking bench for the light curtain monitor
`timescale 1ns/10ps
module light_curtain_monitor_tb;
    logic clock, rst_n, beam, pressBtn, runMode, startupCheck, chOne, chTwo, button;
    logic safeEnableOutput, faultOutput;
    logic [1:0] restartMode;
    logic [2:0] channelSkewLimit;
    logic [15:0] skew;
    logic [light_curtain_pkg::COUNT_W-1:0] skewCount;
    int errorCnt = 0;
    int checkCount = 0;
    // ************************************************
    // clock and instances
    // ************************************************
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // small tick keeps the skew windows short: 2000 cycles per half second
    light_curtain_monitor #(.TICK_CYCLES(4)) dut_u (.clock(clock), .rst_n(rst_n),
        .curtainChannelOne(chOne), .curtainChannelTwo(chTwo), .restartRequestInput(button),
        .runMode(runMode), .restartMode(restartMode), .startupCheck(startupCheck),
        .channelSkewLimit(channelSkewLimit), .safeEnableOutput(safeEnableOutput),
        .faultOutput(faultOutput), .skewCount(skewCount));
    curtain_model model_u (.clock(clock), .beamClear(beam), .skewCycles(skew),
        .pressBtn(pressBtn), .chOne(chOne), .chTwo(chTwo), .button(button));
    // ************************************************
    // tasks
    // ************************************************
    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", errorCnt, checkCount);
        if (errorCnt == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp);
        checkCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_range(input logic [11:0] got, input logic [11:0] lo, input logic [11:0] hi);
        checkCount++;
        // an unknown count must not slip through the range test
        if ((got >= lo && got <= hi) !== 1'b1) begin
            errorCnt++;
            $display("BAD %0t count %h", $time, got);
        end
    endtask
    // which=1 watches fault, else safe; sampled at falling edge, away from updates
    task automatic await(input bit which, input logic v, input int lim);
        logic s;
        for (int i = 0; i < lim; i++) begin
            @(negedge clock);
            s = which ? faultOutput : safeEnableOutput;
            if (s === v) break;
        end
        chk(s, v);
        @(posedge clock);
    endtask
    // value must stand for n cycles; every cycle is one compare
    task automatic hold(input bit which, input logic v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            chk(which ? faultOutput : safeEnableOutput, v);
        end
        @(posedge clock);
    endtask
    task automatic clear(input logic [15:0] k);
        skew <= k;
        beam <= 1'b1;
    endtask
    task automatic press;
        pressBtn <= 1'b1;
        step(10);
        pressBtn <= 1'b0;
        step(10);
    endtask
    // a run/stop change restarts the block with fresh settings
    task automatic restart(input logic [1:0] m, input logic sc, input logic [2:0] lim);
        beam <= 1'b0;
        runMode <= 1'b0;
        restartMode <= m;
        startupCheck <= sc;
        channelSkewLimit <= lim;
        step(10);
        runMode <= 1'b1;
        step(10);
    endtask
    // ************************************************
    // watchdog and main sequence
    // ************************************************
    initial begin
        step(20000);
        errorCnt++;
        complete_run;
    end
    initial begin
        {rst_n, beam, pressBtn, runMode, startupCheck, restartMode, channelSkewLimit} = '0;
        skew = 16'h0000;
        step(3);
        rst_n <= 1'b1;
        step(1);
        chk(safeEnableOutput, 1'b0);
        chk(faultOutput, 1'b0);
        chk_range(skewCount, 12'h000, 12'h000);
        restart(light_curtain_pkg::AUTO_RESTART_MODE, 1'b1, 3'h2);
        clear(16'h0005);
        hold(1'b0, 1'b0, 40);
        chk(safeEnableOutput, 1'b0);
        beam <= 1'b0;
        step(10);
        press();
        clear(16'h0005);
        await(1'b0, 1'b1, 20);
        beam <= 1'b0;
        await(1'b0, 1'b0, 6);
        clear(16'h0005);
        await(1'b0, 1'b1, 20);
        // one second limit tolerates a 1.5 * half second skew
        restart(light_curtain_pkg::MANUAL_RESTART_MODE, 1'b0, 3'h2);
        clear(16'h0bb8);
        step(3050);
        chk(faultOutput, 1'b0);
        chk(safeEnableOutput, 1'b0);
        pressBtn <= 1'b1;
        await(1'b0, 1'b1, 8);
        pressBtn <= 1'b0;
        restart(light_curtain_pkg::CONTROLLED_RESTART_MODE, 1'b0, 3'h1);
        clear(16'h000a);
        step(30);
        pressBtn <= 1'b1;
        step(10);
        chk(safeEnableOutput, 1'b0);
        pressBtn <= 1'b0;
        await(1'b0, 1'b1, 8);
        beam <= 1'b0;
        step(10);
        clear(16'h0834);
        await(1'b1, 1'b1, 2150);
        chk(safeEnableOutput, 1'b0);
        chk_range(skewCount, 12'h1f0, 12'h1f5);
        beam <= 1'b0;
        step(20);
        chk(faultOutput, 1'b1);
        clear(16'h000a);
        await(1'b1, 1'b0, 30);
        chk(safeEnableOutput, 1'b0);
        press();
        await(1'b0, 1'b1, 8);
        // limit zero switches skew monitoring off; code 3 restarts like manual
        restart(2'h3, 1'b0, 3'h0);
        clear(16'h0bb8);
        step(3050);
        chk(faultOutput, 1'b0);
        chk(safeEnableOutput, 1'b0);
        pressBtn <= 1'b1;
        await(1'b0, 1'b1, 8);
        pressBtn <= 1'b0;
        complete_run;
    end
endmodule
